// ### src/jrlc_pkg.sv
// Constants for the receive link configuration block.
// Assumes a byte-wide register map reached by a serial port with a 15-bit address.
package jrlc_pkg;

    // Serial frame: 16 instruction bits (read flag plus address), then 8 data bits
    localparam logic [4:0] JRLC_INSTR_BITS = 5'h10;
    localparam logic [4:0] JRLC_FRAME_BITS = 5'h18;
    localparam int JRLC_READ_FLAG = 15;

    // Register offsets
    localparam logic [14:0] JRLC_OFS_CHECK_STATUS = 15'h0030;
    localparam logic [14:0] JRLC_OFS_SYNC_POWERDOWN = 15'h0203;
    localparam logic [14:0] JRLC_OFS_LINK_SELECT = 15'h0300;
    localparam logic [14:0] JRLC_OFS_LANE_COUNT = 15'h0453;
    localparam logic [14:0] JRLC_OFS_OCTETS_M1 = 15'h0454;
    localparam logic [14:0] JRLC_OFS_FRAMES_M1 = 15'h0455;
    localparam logic [14:0] JRLC_OFS_CONVERTERS_M1 = 15'h0456;
    localparam logic [14:0] JRLC_OFS_RESOLUTION = 15'h0457;
    localparam logic [14:0] JRLC_OFS_SUBCLASS = 15'h0458;
    localparam logic [14:0] JRLC_OFS_VERSION = 15'h0459;
    localparam logic [14:0] JRLC_OFS_DENSITY = 15'h045A;
    localparam logic [14:0] JRLC_OFS_DESKEW = 15'h046C;
    localparam logic [14:0] JRLC_OFS_OCTETS_DIRECT = 15'h0476;
    localparam logic [14:0] JRLC_OFS_CAPTURE = 15'h047D;

    // Slots of the per-link register copy
    localparam int JRLC_LINK_REGS = 11;
    localparam logic [3:0] JRLC_IDX_LANE_COUNT = 4'h0;
    localparam logic [3:0] JRLC_IDX_OCTETS_M1 = 4'h1;
    localparam logic [3:0] JRLC_IDX_FRAMES_M1 = 4'h2;
    localparam logic [3:0] JRLC_IDX_CONVERTERS_M1 = 4'h3;
    localparam logic [3:0] JRLC_IDX_RESOLUTION = 4'h4;
    localparam logic [3:0] JRLC_IDX_SUBCLASS = 4'h5;
    localparam logic [3:0] JRLC_IDX_VERSION = 4'h6;
    localparam logic [3:0] JRLC_IDX_DENSITY = 4'h7;
    localparam logic [3:0] JRLC_IDX_DESKEW = 4'h8;
    localparam logic [3:0] JRLC_IDX_OCTETS_DIRECT = 4'h9;
    localparam logic [3:0] JRLC_IDX_CAPTURE = 4'hA;
    localparam logic [3:0] JRLC_IDX_NONE = 4'hF;

    // Field positions
    localparam int JRLC_DUAL_BIT = 3;
    localparam int JRLC_PAGE_BIT = 2;
    localparam logic [7:0] JRLC_LINK_SELECT_MASK = 8'h0C;
    localparam int JRLC_POWERDOWN_BIT = 0;
    localparam int JRLC_SCRAMBLE_BIT = 7;
    localparam int JRLC_HIGH_DENSITY_BIT = 7;
    localparam int JRLC_ST_DELAY_BIT = 5;
    localparam int JRLC_ST_COMBO_BIT = 3;
    localparam int JRLC_ST_FRAMES_BIT = 2;
    localparam int JRLC_ST_SUBCLASS_BIT = 1;

    // Legal field values
    localparam logic [4:0] JRLC_FRAMES_16 = 5'h0F;
    localparam logic [4:0] JRLC_FRAMES_32 = 5'h1F;
    localparam logic [2:0] JRLC_SUBCLASS_MAX = 3'h1;

    // Reset values
    localparam logic [7:0] JRLC_RESET_BYTE = 8'h00;

    // Supported modes 0..7, 9, 10 as {L-1, M-1, S-1, F-1}, one nibble each
    localparam int JRLC_MODES = 10;
    localparam logic [JRLC_MODES-1:0][15:0] JRLC_MODE_LMSF = {
        16'h0001, 16'h1000, 16'h0103, 16'h1101, 16'h3111,
        16'h3100, 16'h1303, 16'h3301, 16'h7311, 16'h7300};
    // Modes usable with two links: 4 and up
    localparam logic [JRLC_MODES-1:0] JRLC_MODE_DUAL_OK = 10'h3F0;

endpackage

// ### src/jrlc_link_config.sv
// Receive link configuration registers, legality checks and lane controls.
// Assumes serial port pins already synchronous to clk; sclk idles low, data on rising edge.
//
// Behaviour
// - Dual-link select bit high runs two links; low runs one link.
// - Single link accepts modes 0 to 7, 9 and 10; dual link only modes 4 to 7, 9 and 10.
// - Page bit steers per-link parameter writes to link 1, else link 0.
// - Power-down bit turns off the second link's sync request output buffer.
// - Status bit flags an illegal multiframe clock delay.
// - Status bit flags an unsupported lane, converter, octet and sample combination.
// - Status bit flags an illegal frames-per-multiframe value.
// - Status bit flags an illegal subclass version.
// - Deskew bit x enables deskew of lane x; unused lanes cleared by software.
// - Capture bit x lets lane x capture data; set after deskew.
// - Lane-count register bit 7 enables descrambling.
// - Lane-count field holds lanes minus one.
// - Octets field holds octets per frame minus one.
// - Direct octets field holds octets per frame, consistent with minus-one field.
// - Multiframe field holds frames minus one; 0x0F and 0x1F are legal, but one octet per frame needs 0x1F.
// - Converter field holds converters minus one.
// - Subclass field selects subclass 0 or 1; sample bits field fixed.
// - Version field one means the B revision; low field samples minus one.
// - Density bit 7 selects high-density format; control-words field stays zero.
`timescale 1ns/1ps

module jrlc_link_config (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic csb_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic [4:0] multiframeClockDelay,
    output logic sdo,
    output logic sdoOe_n,
    output logic dualLinkMode,
    output logic secondLinkSyncOutBufferOn,
    output logic [1:0] descrambleEnable,
    output logic [15:0] laneDeskewEnable,
    output logic [15:0] laneCaptureEnable,
    output logic [1:0] highDensityFormat,
    output logic [1:0] subclassOne,
    output logic [7:0] configCheckStatus
);

    typedef struct packed {
        logic sclkPrev;
        logic [4:0] bitCount;
        logic [15:0] instr;
        logic [7:0] dataIn;
        logic [7:0] shiftOut;
        logic reading;
        logic sdo;
        logic sdoOe_n;
        logic [7:0] syncPowerdown;
        logic [7:0] linkSelect;
        logic [1:0][jrlc_pkg::JRLC_LINK_REGS-1:0][7:0] linkRegs;
        logic [7:0] status;
        logic dual;
        logic syncBufferOn;
        logic [1:0] descramble;
        logic [15:0] deskew;
        logic [15:0] capture;
        logic [1:0] highDensity;
        logic [1:0] subclass;
    } jrlc_state_type;

    localparam jrlc_state_type JRLC_STATE_RESET = '{
        sclkPrev: 1'b0,
        bitCount: 5'h00,
        instr: 16'h0000,
        dataIn: jrlc_pkg::JRLC_RESET_BYTE,
        shiftOut: jrlc_pkg::JRLC_RESET_BYTE,
        reading: 1'b0,
        sdo: 1'b0,
        sdoOe_n: 1'b1,
        syncPowerdown: jrlc_pkg::JRLC_RESET_BYTE,
        linkSelect: jrlc_pkg::JRLC_RESET_BYTE,
        linkRegs: '0,
        status: jrlc_pkg::JRLC_RESET_BYTE,
        dual: 1'b0,
        syncBufferOn: 1'b1,
        descramble: 2'h0,
        deskew: 16'h0000,
        capture: 16'h0000,
        highDensity: 2'h0,
        subclass: 2'h0
    };

    jrlc_state_type state;
    jrlc_state_type next_state;

    // Slot of a per-link register, or none
    function automatic logic [3:0] jrlcLinkIndex(input logic [14:0] addr);
        logic [3:0] idx;
        idx = jrlc_pkg::JRLC_IDX_NONE;
        if (addr == jrlc_pkg::JRLC_OFS_LANE_COUNT) begin
            idx = jrlc_pkg::JRLC_IDX_LANE_COUNT;
        end else if (addr == jrlc_pkg::JRLC_OFS_OCTETS_M1) begin
            idx = jrlc_pkg::JRLC_IDX_OCTETS_M1;
        end else if (addr == jrlc_pkg::JRLC_OFS_FRAMES_M1) begin
            idx = jrlc_pkg::JRLC_IDX_FRAMES_M1;
        end else if (addr == jrlc_pkg::JRLC_OFS_CONVERTERS_M1) begin
            idx = jrlc_pkg::JRLC_IDX_CONVERTERS_M1;
        end else if (addr == jrlc_pkg::JRLC_OFS_RESOLUTION) begin
            idx = jrlc_pkg::JRLC_IDX_RESOLUTION;
        end else if (addr == jrlc_pkg::JRLC_OFS_SUBCLASS) begin
            idx = jrlc_pkg::JRLC_IDX_SUBCLASS;
        end else if (addr == jrlc_pkg::JRLC_OFS_VERSION) begin
            idx = jrlc_pkg::JRLC_IDX_VERSION;
        end else if (addr == jrlc_pkg::JRLC_OFS_DENSITY) begin
            idx = jrlc_pkg::JRLC_IDX_DENSITY;
        end else if (addr == jrlc_pkg::JRLC_OFS_DESKEW) begin
            idx = jrlc_pkg::JRLC_IDX_DESKEW;
        end else if (addr == jrlc_pkg::JRLC_OFS_OCTETS_DIRECT) begin
            idx = jrlc_pkg::JRLC_IDX_OCTETS_DIRECT;
        end else if (addr == jrlc_pkg::JRLC_OFS_CAPTURE) begin
            idx = jrlc_pkg::JRLC_IDX_CAPTURE;
        end
        return idx;
    endfunction

    // Legality of one link's parameters: {delay, combination, frames, subclass}
    function automatic logic [3:0] jrlcCheck(
        input logic [jrlc_pkg::JRLC_LINK_REGS-1:0][7:0] r,
        input logic [4:0] delay,
        input logic dual
    );
        logic comboOk;
        logic framesBad;
        logic [4:0] frames;
        logic [15:0] entry;
        comboOk = 1'b0;
        frames = r[jrlc_pkg::JRLC_IDX_FRAMES_M1][4:0];
        for (int m = 0; m < jrlc_pkg::JRLC_MODES; m++) begin
            entry = jrlc_pkg::JRLC_MODE_LMSF[m];
            if (jrlc_pkg::JRLC_MODE_DUAL_OK[m] || !dual) begin
                if (r[jrlc_pkg::JRLC_IDX_LANE_COUNT][4:0] == {1'b0, entry[15:12]}
                    && r[jrlc_pkg::JRLC_IDX_CONVERTERS_M1] == {4'h0, entry[11:8]}
                    && r[jrlc_pkg::JRLC_IDX_VERSION][4:0] == {1'b0, entry[7:4]}
                    && r[jrlc_pkg::JRLC_IDX_OCTETS_M1] == {4'h0, entry[3:0]}) begin
                    comboOk = 1'b1;
                end
            end
        end
        // Direct octet count must agree, else the deframer sees two frame sizes
        if (r[jrlc_pkg::JRLC_IDX_OCTETS_DIRECT] != 8'(r[jrlc_pkg::JRLC_IDX_OCTETS_M1] + 8'h01)) begin
            comboOk = 1'b0;
        end
        framesBad = !(frames == jrlc_pkg::JRLC_FRAMES_16 || frames == jrlc_pkg::JRLC_FRAMES_32);
        // One octet per frame forces 32 frames per multiframe
        if (r[jrlc_pkg::JRLC_IDX_OCTETS_M1] == 8'h00 && frames != jrlc_pkg::JRLC_FRAMES_32) begin
            framesBad = 1'b1;
        end
        return {delay > frames,
                !comboOk,
                framesBad,
                r[jrlc_pkg::JRLC_IDX_SUBCLASS][7:5] > jrlc_pkg::JRLC_SUBCLASS_MAX};
    endfunction

    // Register read; unmapped offsets read zero
    function automatic logic [7:0] jrlcReadByte(input logic [14:0] addr, input jrlc_state_type s);
        logic [7:0] data;
        logic [3:0] idx;
        data = 8'h00;
        idx = jrlcLinkIndex(addr);
        if (addr == jrlc_pkg::JRLC_OFS_CHECK_STATUS) begin
            data = s.status;
        end else if (addr == jrlc_pkg::JRLC_OFS_SYNC_POWERDOWN) begin
            data = s.syncPowerdown;
        end else if (addr == jrlc_pkg::JRLC_OFS_LINK_SELECT) begin
            data = s.linkSelect;
        end else if (idx != jrlc_pkg::JRLC_IDX_NONE) begin
            data = s.linkRegs[s.linkSelect[jrlc_pkg::JRLC_PAGE_BIT]][idx];
        end
        return data;
    endfunction

    always_comb begin
        logic [15:0] newInstr;
        logic [7:0] newData;
        logic [3:0] idx;
        logic page;
        logic [3:0] chk0;
        logic [3:0] chk1;
        logic [3:0] err;
        next_state = state;
        newInstr = {state.instr[14:0], sdi};
        newData = {state.dataIn[6:0], sdi};
        page = state.linkSelect[jrlc_pkg::JRLC_PAGE_BIT];
        idx = jrlcLinkIndex(state.instr[14:0]);
        next_state.sclkPrev = sclk;

        if (csb_n) begin
            next_state.bitCount = 5'h00;
            next_state.reading = 1'b0;
            next_state.sdo = 1'b0;
            next_state.sdoOe_n = 1'b1;
        end else if (sclk && !state.sclkPrev) begin
            if (state.bitCount < jrlc_pkg::JRLC_INSTR_BITS) begin
                next_state.instr = newInstr;
            end else if (state.bitCount < jrlc_pkg::JRLC_FRAME_BITS) begin
                next_state.dataIn = newData;
            end
            if (state.bitCount == jrlc_pkg::JRLC_INSTR_BITS - 5'h01
                && newInstr[jrlc_pkg::JRLC_READ_FLAG]) begin
                next_state.reading = 1'b1;
                next_state.shiftOut = jrlcReadByte(newInstr[14:0], state);
            end
            if (state.bitCount == jrlc_pkg::JRLC_FRAME_BITS - 5'h01
                && !state.instr[jrlc_pkg::JRLC_READ_FLAG]) begin
                if (state.instr[14:0] == jrlc_pkg::JRLC_OFS_SYNC_POWERDOWN) begin
                    next_state.syncPowerdown = {7'h00, newData[jrlc_pkg::JRLC_POWERDOWN_BIT]};
                end else if (state.instr[14:0] == jrlc_pkg::JRLC_OFS_LINK_SELECT) begin
                    next_state.linkSelect = newData & jrlc_pkg::JRLC_LINK_SELECT_MASK;
                end else if (idx != jrlc_pkg::JRLC_IDX_NONE) begin
                    next_state.linkRegs[page][idx] = newData;
                end
            end
            // Frames longer than one byte are ignored past the first data byte
            if (state.bitCount < jrlc_pkg::JRLC_FRAME_BITS) begin
                next_state.bitCount = state.bitCount + 5'h01;
            end
        end else if (!sclk && state.sclkPrev && state.reading
                     && state.bitCount >= jrlc_pkg::JRLC_INSTR_BITS
                     && state.bitCount < jrlc_pkg::JRLC_FRAME_BITS) begin
            next_state.sdo = state.shiftOut[7];
            next_state.shiftOut = {state.shiftOut[6:0], 1'b0};
            next_state.sdoOe_n = 1'b0;
        end

        // Status tracks the current parameters every cycle, so it clears by itself
        next_state.dual = next_state.linkSelect[jrlc_pkg::JRLC_DUAL_BIT];
        chk0 = jrlcCheck(next_state.linkRegs[0], multiframeClockDelay, next_state.dual);
        chk1 = jrlcCheck(next_state.linkRegs[1], multiframeClockDelay, next_state.dual);
        err = chk0 | (next_state.dual ? chk1 : 4'h0);
        next_state.status = 8'h00;
        next_state.status[jrlc_pkg::JRLC_ST_DELAY_BIT] = err[3];
        next_state.status[jrlc_pkg::JRLC_ST_COMBO_BIT] = err[2];
        next_state.status[jrlc_pkg::JRLC_ST_FRAMES_BIT] = err[1];
        next_state.status[jrlc_pkg::JRLC_ST_SUBCLASS_BIT] = err[0];

        next_state.syncBufferOn = !next_state.syncPowerdown[jrlc_pkg::JRLC_POWERDOWN_BIT];
        for (int k = 0; k < 2; k++) begin
            // Link 1 controls stay off in single-link use
            if (k == 0 || next_state.dual) begin
                next_state.descramble[k] =
                    next_state.linkRegs[k][jrlc_pkg::JRLC_IDX_LANE_COUNT][jrlc_pkg::JRLC_SCRAMBLE_BIT];
                next_state.deskew[k*8 +: 8] = next_state.linkRegs[k][jrlc_pkg::JRLC_IDX_DESKEW];
                next_state.capture[k*8 +: 8] = next_state.linkRegs[k][jrlc_pkg::JRLC_IDX_CAPTURE];
                next_state.highDensity[k] =
                    next_state.linkRegs[k][jrlc_pkg::JRLC_IDX_DENSITY][jrlc_pkg::JRLC_HIGH_DENSITY_BIT];
                next_state.subclass[k] =
                    next_state.linkRegs[k][jrlc_pkg::JRLC_IDX_SUBCLASS][7:5] == 3'h1;
            end else begin
                next_state.descramble[k] = 1'b0;
                next_state.deskew[k*8 +: 8] = 8'h00;
                next_state.capture[k*8 +: 8] = 8'h00;
                next_state.highDensity[k] = 1'b0;
                next_state.subclass[k] = 1'b0;
            end
        end
    end

    // Reset waits for the enable too, so a frozen block keeps every register
    always_ff @(posedge clk) begin
        if (ce) begin
            if (!rst_n) begin
                state <= JRLC_STATE_RESET;
            end else begin
                state <= next_state;
            end
        end
    end

    assign sdo = state.sdo;
    assign sdoOe_n = state.sdoOe_n;
    assign dualLinkMode = state.dual;
    assign secondLinkSyncOutBufferOn = state.syncBufferOn;
    assign descrambleEnable = state.descramble;
    assign laneDeskewEnable = state.deskew;
    assign laneCaptureEnable = state.capture;
    assign highDensityFormat = state.highDensity;
    assign subclassOne = state.subclass;
    assign configCheckStatus = state.status;

endmodule

// ### tb/jrlc_link_config_sva.sv
// Port-level checks for the receive link configuration block.
// Assumes one clock domain; bound to the design top.
`timescale 1ns/1ps
module jrlc_link_config_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic csb_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic [4:0] multiframeClockDelay,
    input wire logic sdo,
    input wire logic sdoOe_n,
    input wire logic dualLinkMode,
    input wire logic secondLinkSyncOutBufferOn,
    input wire logic [1:0] descrambleEnable,
    input wire logic [15:0] laneDeskewEnable,
    input wire logic [15:0] laneCaptureEnable,
    input wire logic [1:0] highDensityFormat,
    input wire logic [1:0] subclassOne,
    input wire logic [7:0] configCheckStatus
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence sclkFallSeen;
        $past(sclk, 2) && !$past(sclk);
    endsequence
    sequence deselectSeen;
        $past(csb_n) || $past(csb_n, 2);
    endsequence
    csb_release_a: assert property (ce && csb_n |=> sdoOe_n)
        else $error("sdo enable held after deselect");
    drive_in_frame_a: assert property (!sdoOe_n |-> !$past(csb_n))
        else $error("sdo driven while deselected");
    drive_on_fall_a: assert property ($fell(sdoOe_n) |-> sclkFallSeen)
        else $error("sdo drive began off a serial clock fall");
    sdo_on_fall_a: assert property ($changed(sdo) && $past(rst_n) |-> sclkFallSeen or deselectSeen)
        else $error("sdo moved off a serial clock fall");
    single_link_quiet_a: assert property (!dualLinkMode |-> !descrambleEnable[1] &&
        !highDensityFormat[1] && !subclassOne[1] && laneDeskewEnable[15:8] == 8'h00 &&
        laneCaptureEnable[15:8] == 8'h00) else $error("second link active in single mode");
    zero_delay_legal_a: assert property (ce && multiframeClockDelay == 5'h00 |=>
        !configCheckStatus[5]) else $error("zero delay flagged illegal");
    status_spare_zero_a: assert property (configCheckStatus[7:6] == 2'h0 &&
        !configCheckStatus[4] && !configCheckStatus[0]) else $error("spare status bit set");
    reset_defaults_a: assert property ($rose(rst_n) && $past(ce) |->
        secondLinkSyncOutBufferOn && !dualLinkMode && laneCaptureEnable == 16'h0000)
        else $error("reset values wrong");
    lanes_by_write_a: assert property (($changed(laneCaptureEnable) ||
        $changed(laneDeskewEnable) || $changed(dualLinkMode)) && $past(rst_n) &&
        $past(rst_n, 2) |-> !$past(csb_n, 2)) else $error("lane control moved without write");
endmodule
bind jrlc_link_config jrlc_link_config_sva chk (.clk(clk), .rst_n(rst_n), .ce(ce),
    .csb_n(csb_n), .sclk(sclk), .sdi(sdi), .multiframeClockDelay(multiframeClockDelay),
    .sdo(sdo), .sdoOe_n(sdoOe_n), .dualLinkMode(dualLinkMode),
    .secondLinkSyncOutBufferOn(secondLinkSyncOutBufferOn), .descrambleEnable(descrambleEnable),
    .laneDeskewEnable(laneDeskewEnable), .laneCaptureEnable(laneCaptureEnable),
    .highDensityFormat(highDensityFormat), .subclassOne(subclassOne),
    .configCheckStatus(configCheckStatus));

// ### tb/jrlc_spi_host.sv
// Configuring host model: serial port master, one byte per frame.
// Assumes sclk held two clk cycles per level; drives on clk falling edge.
`timescale 1ns/1ps
module jrlc_spi_host (
    input wire logic clk,
    input wire logic sdo,
    input wire logic sdoOe_n,
    output logic csb_n,
    output logic sclk,
    output logic sdi
);
    initial begin
        csb_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    task automatic xfer(input logic rd, input logic [14:0] adr, input logic [7:0] wd,
        output logic [7:0] rdat);
        logic [23:0] frame;
        frame = {rd, adr, wd};
        rdat = 8'h00;
        @(negedge clk);
        csb_n = 1'b0;
        @(negedge clk);
        for (int i = 23; i >= 0; i--) begin
            sdi = frame[i];
            sclk = 1'b1;
            repeat (2) @(negedge clk);
            // Undriven line must not pass as data
            if (i < 8) rdat[i] = sdoOe_n ? 1'bx : sdo;
            sclk = 1'b0;
            repeat (2) @(negedge clk);
        end
        csb_n = 1'b1;
        // Deselected data line toggles, not a stale bit
        sdi = ~sdi;
        @(negedge clk);
    endtask
endmodule

// ### tb/tb_jrlc_link_config.sv
// Self-checking bench for the receive link configuration block.
// Assumes the host model speaks the serial register protocol.
`timescale 1ns/1ps
module tb_jrlc_link_config;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [4:0] multiframeClockDelay = 5'h00;
    logic csb_n, sclk, sdi, sdo, sdoOe_n, dualLinkMode, secondLinkSyncOutBufferOn;
    logic [1:0] descrambleEnable, highDensityFormat, subclassOne;
    logic [15:0] laneDeskewEnable, laneCaptureEnable;
    logic [7:0] configCheckStatus, rdat;
    int nFail = 0;
    int totalChecks = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    jrlc_spi_host host (.clk(clk), .sdo(sdo), .sdoOe_n(sdoOe_n), .csb_n(csb_n),
        .sclk(sclk), .sdi(sdi));
    jrlc_link_config dut (.clk(clk), .rst_n(rst_n), .ce(ce), .csb_n(csb_n), .sclk(sclk),
        .sdi(sdi), .multiframeClockDelay(multiframeClockDelay), .sdo(sdo), .sdoOe_n(sdoOe_n),
        .dualLinkMode(dualLinkMode), .secondLinkSyncOutBufferOn(secondLinkSyncOutBufferOn),
        .descrambleEnable(descrambleEnable), .laneDeskewEnable(laneDeskewEnable),
        .laneCaptureEnable(laneCaptureEnable), .highDensityFormat(highDensityFormat),
        .subclassOne(subclassOne), .configCheckStatus(configCheckStatus));
    task automatic completeRun();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Ceiling well above the roughly 6000 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            nFail++;
            completeRun();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        totalChecks++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.xfer(1'b0, a, d, rdat);
    endtask
    task automatic rdChk(input logic [14:0] a, input logic [7:0] exp);
        host.xfer(1'b1, a, 8'h00, rdat);
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdat});
    endtask
    task automatic st(input logic [7:0] mask, input logic [7:0] exp);
        chk("status", {8'h00, exp}, {8'h00, configCheckStatus & mask});
    endtask
    task automatic dly(input logic [4:0] d, input logic [7:0] exp);
        multiframeClockDelay = d;
        repeat (2) @(negedge clk);
        st(8'hFF, exp);
    endtask
    task automatic cfg(input logic [7:0] lc, f1, k1, m1, s1, hd);
        wr(15'h0453, lc);
        wr(15'h0454, f1);
        wr(15'h0455, k1);
        wr(15'h0456, m1);
        wr(15'h0457, 8'h0F);
        wr(15'h0458, 8'h2F);
        wr(15'h0459, 8'h20 | s1);
        wr(15'h045A, hd);
        wr(15'h0476, f1 + 8'h01);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        st(8'h2C, 8'h0C);
        chk("buffer on", 16'h0001, {15'h0000, secondLinkSyncOutBufferOn});
        rdChk(15'h0300, 8'h00);
        $display("test reset done");
        cfg(8'h87, 8'h00, 8'h1F, 8'h03, 8'h00, 8'h80);
        st(8'hFF, 8'h00);
        chk("fields", 16'h0015,
            {10'h000, descrambleEnable, highDensityFormat, subclassOne});
        wr(15'h046C, 8'hFF);
        wr(15'h047D, 8'hFF);
        chk("deskew", 16'h00FF, laneDeskewEnable);
        chk("capture", 16'h00FF, laneCaptureEnable);
        rdChk(15'h0453, 8'h87);
        wr(15'h0455, 8'h10);
        st(8'hFF, 8'h04);
        wr(15'h0455, 8'h0F);
        st(8'hFF, 8'h04);
        wr(15'h0455, 8'h1F);
        st(8'hFF, 8'h00);
        $display("test mode zero done");
        cfg(8'h07, 8'h01, 8'h0F, 8'h03, 8'h01, 8'h00);
        st(8'hFF, 8'h00);
        dly(5'h10, 8'h20);
        dly(5'h0F, 8'h00);
        wr(15'h0458, 8'h4F);
        st(8'hFF, 8'h02);
        chk("subclass", 16'h0000, {14'h0000, subclassOne});
        wr(15'h0458, 8'h2F);
        wr(15'h0476, 8'h03);
        st(8'hFF, 8'h08);
        wr(15'h0476, 8'h02);
        $display("test mode one done");
        cfg(8'h00, 8'h01, 8'h0F, 8'h00, 8'h00, 8'h00);
        st(8'hFF, 8'h00);
        wr(15'h0300, 8'h0C);
        st(8'hFF, 8'h2C);
        cfg(8'h00, 8'h01, 8'h0F, 8'h00, 8'h00, 8'h00);
        wr(15'h046C, 8'h01);
        wr(15'h047D, 8'h01);
        st(8'hFF, 8'h00);
        chk("dual", 16'h0001, {15'h0000, dualLinkMode});
        chk("deskew", 16'h01FF, laneDeskewEnable);
        chk("capture", 16'h01FF, laneCaptureEnable);
        rdChk(15'h046C, 8'h01);
        wr(15'h0300, 8'h08);
        rdChk(15'h046C, 8'hFF);
        wr(15'h0453, 8'h03);
        wr(15'h0456, 8'h03);
        st(8'hFF, 8'h08);
        wr(15'h0300, 8'h00);
        st(8'hFF, 8'h00);
        chk("single", 16'h00FF, laneCaptureEnable);
        $display("test dual link done");
        wr(15'h0203, 8'hFF);
        chk("buffer off", 16'h0000, {15'h0000, secondLinkSyncOutBufferOn});
        rdChk(15'h0203, 8'h01);
        wr(15'h0030, 8'hFF);
        rdChk(15'h0030, 8'h00);
        rdChk(15'h0001, 8'h00);
        // Clock enable low must also hold off reset
        ce = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        ce = 1'b1;
        repeat (2) @(negedge clk);
        chk("frozen", 16'h00FF, laneDeskewEnable);
        $display("test misc done");
        completeRun();
    end
endmodule
